// file: src/pin_sync.sv
/*
 * Two-flop synchroniser for a vector of asynchronous pins.
 * Assumes each bit is an independent level; no bus coherence.
 */
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_i, // Core clock
	input wire logic rst_n_i, // Async reset, active low
	input wire logic [W-1:0] d_i, // Raw pin levels
	output logic [W-1:0] q_o // Synchronised levels
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} sync_t;

	sync_t q, d;

	// First stage only feeds the second
	always_comb begin
		d = q;
		d.meta = d_i;
		d.sync = q.meta;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign q_o = q.sync;

endmodule

// file: src/pm_pkg.sv
/*
 * Shared constants and types of the stop-mode power controller.
 * Assumes a 40 MHz core clock and a 32-bit APB register bus.
 */
package pm_pkg;

	// ----------------------------------------
	// Bus and counter widths
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int PC_W = 16;
	localparam int WU_W = 16;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [11:0] OFS_SYSCTL = 12'h000;
	localparam logic [11:0] OFS_WUCFG = 12'h004;
	localparam logic [11:0] OFS_MODE = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;
	localparam logic [11:0] OFS_PC = 12'h010;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_STOP = 7;
	localparam int BIT_RELEASE_MODE_SELECT = 6;
	localparam int BIT_HOLD = 4;
	localparam int BIT_WUSEL = 16;
	localparam int BIT_IDLE = 0;
	localparam int BIT_SLEEP = 1;
	localparam int POS_TBSEL = 2;
	localparam int BIT_REFUSED = 3;

	// ----------------------------------------
	// Pin vector layout and reset values
	// ----------------------------------------
	localparam int PIN_W = 9;
	localparam int PIN_REL = 0;
	localparam int PIN_KEY = 1;
	localparam int PIN_VDET = 2;
	localparam int PIN_HF = 3;
	localparam int PIN_LF = 4;
	localparam int PIN_TB = 5;
	localparam logic [15:0] WU_TERM_RST = 16'h00ff;

	// Power mode states
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_STOP = 3'b001,
		ST_WARMUP = 3'b010,
		ST_IDLE = 3'b011,
		ST_SLEEP = 3'b100
	} pm_state_t;

endpackage

// file: src/stop_mode_power_control.sv
/*
 * Stop-mode power controller with APB register access.
 * Assumes oscillator ticks and wake pins arrive asynchronously,
 * and that the core supplies the address two instructions ahead.
 */
// Implementation choices: the APB register port and the address map.
// Summary of operation
// - Writing stop bit one enters full stop
// - Full stop halts both oscillators and activity
// - Memory, registers, status word kept in stop
// - Output hold bit sets port latch behaviour
// - Entry clears timing prescaler and divider
// - Program counter held two instructions ahead
// - Release by pin, key wakeup or voltage
// - Resets also end full stop
// - After reset: warm-up, then single-clock mode
// - External interrupt latches may set while stopped
// - Release mode bit picks level or edge
// - Level mode releases when pin goes high
// - Level mode refuses entry with pin high
// - No re-entry once warm-up has begun
// - Warm-up counts on entry system clock
// - Release pin doubles as port and interrupt
// - Timer idle and sleep end on falling edge
// - Edge mode releases on rising pin edge
// - Warm-up completes with internal operation halted
// - Release path resumes previous mode, next instruction
`timescale 1ns/1ps
module stop_mode_power_control (
	input wire logic MCLK_I, // Core clock, 40 MHz
	input wire logic RST_N_I, // Any chip reset, active low
	input wire logic PSEL_I, // APB select
	input wire logic PENABLE_I, // APB access phase
	input wire logic PWRITE_I, // APB write
	input wire logic [pm_pkg::ADDR_W-1:0] PADDR_I, // APB byte address
	input wire logic [pm_pkg::DATA_W-1:0] PWDATA_I, // APB write data
	output logic PREADY_O, // APB ready
	output logic [pm_pkg::DATA_W-1:0] PRDATA_O, // APB read data
	output logic PSLVERR_O, // APB error on unmapped address
	input wire logic RELEASE_PIN_I, // Stop release pin level
	input wire logic KEY_WAKE_I, // Key-on wakeup request
	input wire logic VDET_WAKE_I, // Voltage detection release
	input wire logic HF_TICK_I, // High-frequency divided tick
	input wire logic LF_TICK_I, // Low-frequency divided tick
	input wire logic [3:0] TB_SRC_I, // Time-base source clocks
	input wire logic SYS_ON_LF_I, // Main clock from low-frequency
	input wire logic DUAL_CLOCK_I, // Dual-clock mode active
	input wire logic [pm_pkg::PC_W-1:0] NEXT2_PC_I, // PC two ahead
	output logic HF_OSC_EN_O, // High-frequency oscillator on
	output logic LF_OSC_EN_O, // Low-frequency oscillator on
	output logic CORE_CLK_EN_O, // Core clock running
	output logic PERIPH_CLK_EN_O, // Peripheral clocks running
	output logic TG_CLEAR_O, // Clear prescaler and divider
	output logic PORT_HOLD_O, // Port output latch held
	output logic [pm_pkg::PC_W-1:0] HELD_PC_O, // Resume address
	output logic EXT_EXTERNAL_INTERRUPT_FIVE_O, // External interrupt five event
	output logic SHARED_PORT_BIT_O, // Pin level as port bit
	output logic RESUME_O, // Pulse when warm-up ends and execution resumes
	output logic RESUME_SINGLE_O // Resumed from reset into single-clock
);
	import pm_pkg::*;

	// ----------------------------------------
	// State record
	// ----------------------------------------
	typedef struct packed {
		pm_state_t st;
		logic stop_req;
		logic release_mode_select;
		logic port_output_hold_enable;
		logic [WU_W-1:0] wu_term;
		logic wu_sel;
		logic [1:0] tb_sel;
		logic refused;
		logic from_reset;
		logic [2:0] wake_src;
		logic ent_lf;
		logic ent_dual;
		logic [PC_W-1:0] held_pc;
		logic [PIN_W-1:0] prev;
		logic rel_mask;
		logic pready;
		logic [DATA_W-1:0] prdata;
		logic pslverr;
		logic hf_en;
		logic lf_en;
		logic core_en;
		logic per_en;
		logic tg_clr;
		logic port_hold;
		logic external_interrupt_five;
		logic wu_start;
		logic resume;
		logic res_single;
	} pm_t;

	pm_t q, d;
	logic [PIN_W-1:0] sy;
	logic wu_tick;
	logic wu_done;

	// ----------------------------------------
	// Pin synchronisers and warm-up counter
	// ----------------------------------------
	pin_sync #(
		.W(PIN_W)
	) u_sync (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.d_i({TB_SRC_I, LF_TICK_I, HF_TICK_I, VDET_WAKE_I, KEY_WAKE_I, RELEASE_PIN_I}),
		.q_o(sy)
	);

	warmup_counter u_wu (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.start_i(q.wu_start),
		.tick_i(wu_tick),
		.term_i(q.wu_term),
		.done_o(wu_done)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// Decoded strobes shared by the next-state process
	logic acc;
	logic wr;
	logic rel_pin;
	logic any_rel;
	logic tb_fall;
	logic hf_rise;
	logic lf_rise;
	logic sel_lf;
	logic [1:0] tb_idx;

	// Edge detects read only the second sync stage
	always_comb begin
		hf_rise = sy[PIN_HF] & ~q.prev[PIN_HF];
		lf_rise = sy[PIN_LF] & ~q.prev[PIN_LF];
		// Reset warm-up honours the select bit; release uses entry clock
		sel_lf = q.from_reset ? q.wu_sel : q.ent_lf;
		wu_tick = sel_lf ? lf_rise : hf_rise;
		// Level or edge form of the release pin
		rel_pin = q.release_mode_select ? sy[PIN_REL]
			: (sy[PIN_REL] & ~q.prev[PIN_REL] & ~q.rel_mask);
		any_rel = rel_pin | sy[PIN_KEY] | sy[PIN_VDET];
		// Idle and sleep wake on a falling time-base edge
		tb_idx = q.tb_sel;
		tb_fall = ~sy[PIN_TB + int'(tb_idx)] & q.prev[PIN_TB + int'(tb_idx)];
		// Write lands in the ready cycle, once per transfer
		acc = PSEL_I & PENABLE_I;
		wr = acc & q.pready & PWRITE_I;
	end

	always_comb begin
		d = q;
		// Edge history follows the pins; pulses and masks default low
		d.prev = sy;
		d.rel_mask = 1'b0;
		d.tg_clr = 1'b0;
		d.wu_start = 1'b0;
		d.resume = 1'b0;
		// Pin doubles as port bit and interrupt source, even when stopped
		d.external_interrupt_five = sy[PIN_REL] & ~q.prev[PIN_REL];

		// ----------------------------------------
		// Register bus
		// ----------------------------------------
		// APB: one wait state, read data sampled in the first access cycle
		d.pready = acc & ~q.pready;
		// Error flag stands only beside ready, so it clears every cycle
		d.pslverr = 1'b0;
		if (acc && !q.pready) begin
			d.pslverr = 1'b0;
			case (PADDR_I)
				OFS_SYSCTL: begin
					d.prdata = {24'h000000, q.stop_req, q.release_mode_select, 1'b0, q.port_output_hold_enable, 4'h0};
				end
				OFS_WUCFG: begin
					d.prdata = {15'h0000, q.wu_sel, q.wu_term};
				end
				OFS_MODE: begin
					d.prdata = {28'h0000000, q.tb_sel, 2'b00};
				end
				OFS_STATUS: begin
					d.prdata = {22'h000000, sy[PIN_REL], q.ent_lf, q.wake_src,
						q.from_reset, q.refused, q.st};
				end
				OFS_PC: begin
					d.prdata = {16'h0000, q.held_pc};
				end
				default: begin
					d.prdata = 32'h00000000;
					d.pslverr = 1'b1;
				end
			endcase
		end

		// Configuration writes; stop and idle bits handled in the FSM
		if (wr) begin
			case (PADDR_I)
				OFS_SYSCTL: begin
					d.release_mode_select = PWDATA_I[BIT_RELEASE_MODE_SELECT];
					d.port_output_hold_enable = PWDATA_I[BIT_HOLD];
				end
				OFS_WUCFG: begin
					d.wu_term = PWDATA_I[WU_W-1:0];
					d.wu_sel = PWDATA_I[BIT_WUSEL];
				end
				OFS_MODE: begin
					d.tb_sel = PWDATA_I[POS_TBSEL+1:POS_TBSEL];
				end
				OFS_STATUS: begin
					if (PWDATA_I[BIT_REFUSED]) begin
						d.refused = 1'b0;
					end
				end
				default: begin
					// Unmapped writes are dropped; the error went out with ready
					d.pslverr = 1'b0;
				end
			endcase
		end

		// ----------------------------------------
		// Power mode sequencer
		// ----------------------------------------
		case (q.st)
			ST_RUN: begin
				if (wr && PADDR_I == OFS_SYSCTL && PWDATA_I[BIT_STOP]) begin
					// New release mode applies to this entry check
					if (PWDATA_I[BIT_RELEASE_MODE_SELECT] && sy[PIN_REL]) begin
						d.refused = 1'b1;
					end else begin
						d.st = ST_STOP;
						d.stop_req = 1'b1;
						d.hf_en = 1'b0;
						d.lf_en = 1'b0;
						d.core_en = 1'b0;
						d.per_en = 1'b0;
						d.tg_clr = 1'b1;
						d.held_pc = NEXT2_PC_I;
						d.ent_lf = SYS_ON_LF_I;
						d.ent_dual = DUAL_CLOCK_I;
						d.from_reset = 1'b0;
						d.res_single = 1'b0;
						// Mask the first stop cycle so an edge racing the entry is
						// not taken; the port bit and interrupt still see it
						d.rel_mask = 1'b1;
					end
				end else if (wr && PADDR_I == OFS_MODE && PWDATA_I[BIT_SLEEP]) begin
					// Sleep stops the high-frequency oscillator as well
					d.st = ST_SLEEP;
					d.core_en = 1'b0;
					d.per_en = 1'b0;
					d.hf_en = 1'b0;
				end else if (wr && PADDR_I == OFS_MODE && PWDATA_I[BIT_IDLE]) begin
					// Idle keeps both oscillators; only core and peripherals stop
					d.st = ST_IDLE;
					d.core_en = 1'b0;
					d.per_en = 1'b0;
				end
			end
			ST_STOP: begin
				// Key and voltage requests are levels, taken at once
				if (any_rel) begin
					d.st = ST_WARMUP;
					d.wu_start = 1'b1;
					// Kept so software can see why it woke
					d.wake_src = {sy[PIN_VDET], sy[PIN_KEY], rel_pin};
					// Restart only the oscillators the entry mode used
					d.hf_en = ~q.ent_lf;
					d.lf_en = q.ent_dual;
				end
			end
			ST_WARMUP: begin
				// Pin activity is ignored here, so no re-entry
				if (wu_done) begin
					d.st = ST_RUN;
					d.core_en = 1'b1;
					d.per_en = 1'b1;
					// Timing generator restarts from zero with execution
					d.tg_clr = 1'b1;
					d.stop_req = 1'b0;
					d.resume = 1'b1;
					d.res_single = q.from_reset;
				end
			end
			ST_IDLE, ST_SLEEP: begin
				// Rising edges of the time-base source are ignored
				if (tb_fall) begin
					d.st = ST_RUN;
					d.core_en = 1'b1;
					d.per_en = 1'b1;
				end
			end
			default: begin
				d.st = ST_RUN;
			end
		endcase

		// Latch hold follows the hold bit while stopped or warming
		d.port_hold = d.port_output_hold_enable & (d.st == ST_STOP || d.st == ST_WARMUP);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Reset lands in warm-up so every reset exit passes it
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			q <= '0;
			q.st <= ST_WARMUP;
			q.from_reset <= 1'b1;
			q.wu_start <= 1'b1;
			q.hf_en <= 1'b1;
			q.wu_term <= WU_TERM_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Outputs, all from flops
	// ----------------------------------------
	// Every output is a plain flop, no gating on the way out
	assign PREADY_O = q.pready;
	assign PRDATA_O = q.prdata;
	assign PSLVERR_O = q.pslverr;
	assign HF_OSC_EN_O = q.hf_en;
	assign LF_OSC_EN_O = q.lf_en;
	assign CORE_CLK_EN_O = q.core_en;
	assign PERIPH_CLK_EN_O = q.per_en;
	assign TG_CLEAR_O = q.tg_clr;
	assign PORT_HOLD_O = q.port_hold;
	assign HELD_PC_O = q.held_pc;
	assign EXT_EXTERNAL_INTERRUPT_FIVE_O = q.external_interrupt_five;
	assign SHARED_PORT_BIT_O = q.prev[PIN_REL];
	assign RESUME_O = q.resume;
	assign RESUME_SINGLE_O = q.res_single;

endmodule

// file: src/warmup_counter.sv
/*
 * Oscillator warm-up counter: counts ticks up to a terminal value.
 * Assumes start and tick are single-cycle pulses on the core clock.
 */
`timescale 1ns/1ps
module warmup_counter (
	input wire logic clk_i, // Core clock
	input wire logic rst_n_i, // Async reset, active low
	input wire logic start_i, // Restart the count
	input wire logic tick_i, // One oscillator tick
	input wire logic [pm_pkg::WU_W-1:0] term_i, // Terminal count
	output logic done_o // Pulse at terminal count
);
	import pm_pkg::*;

	typedef struct packed {
		logic [WU_W-1:0] cnt;
		logic busy;
		logic done;
	} wu_t;

	wu_t q, d;

	// Start wins over a tick in the same cycle
	always_comb begin
		d = q;
		d.done = 1'b0;
		if (start_i) begin
			d.cnt = '0;
			d.busy = 1'b1;
		end else if (q.busy && tick_i) begin
			d.cnt = q.cnt + 16'h0001;
			if (d.cnt >= term_i) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done_o = q.done;

endmodule

// file: verification/pm_chk.sv
/* Port checker for the stop-mode power controller.
   Bound to the top module; sees only its ports. */
`timescale 1ns/1ps
module pm_chk (
	input wire logic MCLK_I, // Clock
	input wire logic RST_N_I, // Reset
	input wire logic PSEL_I, // Select
	input wire logic PENABLE_I, // Access
	input wire logic PREADY_O, // Ready
	input wire logic PSLVERR_O, // Error
	input wire logic RELEASE_PIN_I, // Pin
	input wire logic [pm_pkg::PC_W-1:0] NEXT2_PC_I, // Next PC
	input wire logic HF_OSC_EN_O, // HF on
	input wire logic LF_OSC_EN_O, // LF on
	input wire logic CORE_CLK_EN_O, // Core on
	input wire logic PERIPH_CLK_EN_O, // Periph on
	input wire logic TG_CLEAR_O, // Clear
	input wire logic PORT_HOLD_O, // Hold
	input wire logic [pm_pkg::PC_W-1:0] HELD_PC_O, // Held PC
	input wire logic EXT_EXTERNAL_INTERRUPT_FIVE_O, // Int five
	input wire logic SHARED_PORT_BIT_O, // Port bit
	input wire logic RESUME_O // Resume
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	// Entry step: clear pulse while the core is off
	sequence s_entry;
		TG_CLEAR_O && !CORE_CLK_EN_O;
	endsequence
	// Pin held steady long enough to pass the synchroniser
	sequence s_pin_hi;
		RELEASE_PIN_I [*4];
	endsequence
	property p_one_wait;
		PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("no ready after wait");
	property p_ready_pulse;
		PREADY_O |=> !PREADY_O;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
	property p_err_ready;
		PSLVERR_O |-> PREADY_O;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_halt;
		s_entry |-> !HF_OSC_EN_O && !LF_OSC_EN_O && !PERIPH_CLK_EN_O;
	endproperty
	a_halt: assert property (p_halt) else $error("clock left on in stop");
	property p_pc;
		s_entry |-> HELD_PC_O == $past(NEXT2_PC_I);
	endproperty
	a_pc: assert property (p_pc) else $error("held address wrong");
	property p_hold;
		PORT_HOLD_O |-> !CORE_CLK_EN_O;
	endproperty
	a_hold: assert property (p_hold) else $error("hold while running");
	property p_port;
		s_pin_hi |=> SHARED_PORT_BIT_O;
	endproperty
	a_port: assert property (p_port) else $error("port bit stale");
	property p_external_interrupt_five;
		$rose(SHARED_PORT_BIT_O) |-> EXT_EXTERNAL_INTERRUPT_FIVE_O || $past(EXT_EXTERNAL_INTERRUPT_FIVE_O);
	endproperty
	a_external_interrupt_five: assert property (p_external_interrupt_five) else $error("no interrupt five");
	property p_resume;
		RESUME_O |-> CORE_CLK_EN_O && PERIPH_CLK_EN_O;
	endproperty
	a_resume: assert property (p_resume) else $error("resume with clocks off");
endmodule
bind stop_mode_power_control pm_chk u_chk (.MCLK_I, .RST_N_I, .PSEL_I, .PENABLE_I,
	.PREADY_O, .PSLVERR_O, .RELEASE_PIN_I, .NEXT2_PC_I, .HF_OSC_EN_O, .LF_OSC_EN_O,
	.CORE_CLK_EN_O, .PERIPH_CLK_EN_O, .TG_CLEAR_O, .PORT_HOLD_O, .HELD_PC_O,
	.EXT_EXTERNAL_INTERRUPT_FIVE_O, .SHARED_PORT_BIT_O, .RESUME_O);

// file: verification/pm_osc_model.sv
/* Oscillator model: divided ticks from both oscillators.
   Assumes the enables come from the controller. */
`timescale 1ns/1ps
module pm_osc_model (
	input wire logic clk_i, // Core clock
	input wire logic hf_en_i, // HF enable
	input wire logic lf_en_i, // LF enable
	output logic hf_tick_o, // HF tick
	output logic lf_tick_o // LF tick
);
	logic [1:0] cnt_q = 2'h0;
	// Free divider; gating freezes ticks so a wrong source hangs
	always_ff @(posedge clk_i) begin
		cnt_q <= cnt_q + 2'h1;
	end
	assign hf_tick_o = hf_en_i & cnt_q[1];
	assign lf_tick_o = lf_en_i & cnt_q[1];
endmodule

// file: verification/stop_mode_power_control_tb.sv
/* Testbench for the stop-mode power controller.
   Assumes the oscillator model and the bound checker. */
`timescale 1ns/1ps
module stop_mode_power_control_tb;
	import pm_pkg::*;
	logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic pin = 0, key = 0, vdet = 0, sys_lf = 0, dual = 0;
	logic [3:0] tb_src = 4'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [15:0] pc = 16'h0, held_pc;
	logic pready, pslverr, rerr, hf_en, lf_en, core_en, per_en, tg_clr, hold;
	logic external_interrupt_five, port_bit, resume, res_single, hf_tick, lf_tick;
	int mismatches = 0, check_count = 0;
	logic external_interrupt_five_latch = 0, external_interrupt_five_clr = 0;
	stop_mode_power_control DUT (.MCLK_I(mclk), .RST_N_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr), .RELEASE_PIN_I(pin),
		.KEY_WAKE_I(key), .VDET_WAKE_I(vdet), .HF_TICK_I(hf_tick), .LF_TICK_I(lf_tick),
		.TB_SRC_I(tb_src), .SYS_ON_LF_I(sys_lf), .DUAL_CLOCK_I(dual), .NEXT2_PC_I(pc),
		.HF_OSC_EN_O(hf_en), .LF_OSC_EN_O(lf_en), .CORE_CLK_EN_O(core_en),
		.PERIPH_CLK_EN_O(per_en), .TG_CLEAR_O(tg_clr), .PORT_HOLD_O(hold),
		.HELD_PC_O(held_pc), .EXT_EXTERNAL_INTERRUPT_FIVE_O(external_interrupt_five), .SHARED_PORT_BIT_O(port_bit),
		.RESUME_O(resume), .RESUME_SINGLE_O(res_single));
	pm_osc_model u_osc (.clk_i(mclk), .hf_en_i(hf_en), .lf_en_i(lf_en),
		.hf_tick_o(hf_tick), .lf_tick_o(lf_tick));
	// Software view of the interrupt five latch; the event wins over a clear
	always @(posedge mclk) begin
		if (external_interrupt_five) begin
			external_interrupt_five_latch <= 1;
		end else if (external_interrupt_five_clr) begin
			external_interrupt_five_latch <= 0;
		end
	end
	// ----------------------------------------
	// Bus and check helpers
	// ----------------------------------------
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	// Request held until ready is seen at an edge; only the watchdog ends a hang
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x, input string m);
		check_count++;
		if (g !== x) begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	// Bounded wait on resume (k=0) or core clock (k=1)
	task wait_for(input int k, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while ((k ? core_en : resume) !== 1'b1 && n < lim);
		chk(n < lim, 1, "wake timed out");
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_boot;
		wait_for(0, 3000);
		chk(res_single, 1, "boot resume kind");
		apb(0, OFS_STATUS, 0);
		chk(rdat[4:0], 5'h10, "boot status");
	endtask
	task t_map;
		apb(1, OFS_WUCFG, 32'h2);
		apb(0, OFS_WUCFG, 0);
		chk(rdat, 32'h2, "terminal readback");
		apb(0, 12'h020, 0);
		chk(rerr, 1, "unmapped read error");
		chk(rdat, 32'h0, "unmapped read data");
	endtask
	task t_refuse;
		pin <= 1;
		apb(1, OFS_SYSCTL, 32'hc0);
		apb(0, OFS_STATUS, 0);
		chk(rdat[3:0], 4'h8, "level entry not refused");
		apb(1, OFS_STATUS, 32'h8);
		pin <= 0;
	endtask
	task t_level;
		pc <= 16'h1234;
		repeat (4) @(posedge mclk);
		apb(0, OFS_STATUS, 0);
		chk(rdat[9], 0, "pin not low");
		apb(1, OFS_SYSCTL, 32'hd0);
		@(posedge mclk);
		chk(tg_clr, 1, "no entry clear pulse");
		@(posedge mclk);
		chk({hf_en, lf_en, core_en, per_en}, 4'h0, "clocks in stop");
		chk(hold, 1, "port hold");
		chk(held_pc, 16'h1234, "held address");
		pin <= 1;
		repeat (8) @(posedge mclk);
		pin <= 0;
		wait_for(0, 300);
		chk(res_single, 0, "release resume kind");
		apb(0, OFS_STATUS, 0);
		chk(rdat[7:0], 8'h20, "pin wake status");
	endtask
	task t_edge;
		pin <= 1;
		repeat (4) @(posedge mclk);
		apb(1, OFS_SYSCTL, 32'h80);
		external_interrupt_five_clr <= 1;
		apb(0, OFS_STATUS, 0);
		external_interrupt_five_clr <= 0;
		chk(external_interrupt_five_latch, 0, "latch not cleared before stop");
		chk(rdat[2:0], 3'h1, "edge entry with pin high");
		chk(hold, 0, "hold off");
		pin <= 0;
		repeat (4) @(posedge mclk);
		pin <= 1;
		wait_for(0, 300);
		chk(core_en, 1, "edge release");
		chk(external_interrupt_five_latch, 1, "interrupt five not latched in stop");
		pin <= 0;
		external_interrupt_five_clr <= 1;
		@(posedge mclk);
		external_interrupt_five_clr <= 0;
	endtask
	task t_wake;
		logic b;
		for (int i = 0; i < 2; i++) begin
			b = i[0];
			sys_lf <= b;
			dual <= b;
			apb(1, OFS_SYSCTL, 32'h80);
			repeat (2) @(posedge mclk);
			vdet <= b;
			key <= ~b;
			repeat (8) @(posedge mclk);
			chk({hf_en, lf_en}, {~b, b}, "warm-up oscillators");
			key <= 0;
			vdet <= 0;
			wait_for(0, 300);
			apb(0, OFS_STATUS, 0);
			chk(rdat[8:5], {b, b, ~b, 1'b0}, "wake source");
		end
		sys_lf <= 0;
		dual <= 0;
	endtask
	task t_idle;
		for (int i = 0; i < 2; i++) begin
			apb(1, OFS_MODE, i ? 32'h6 : 32'h1);
			repeat (2) @(posedge mclk);
			chk(core_en, 0, "idle entry");
			tb_src[i] <= 1;
			repeat (6) @(posedge mclk);
			chk(core_en, 0, "rising edge ends idle");
			tb_src[i] <= 0;
			wait_for(1, 20);
		end
	endtask
	task t_reset;
		apb(1, OFS_SYSCTL, 32'h80);
		repeat (3) @(posedge mclk);
		rst_n <= 0;
		repeat (2) @(posedge mclk);
		rst_n <= 1;
		wait_for(0, 3000);
		chk({res_single, hf_en}, 2'h3, "reset exit");
	endtask
	task end_of_test;
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1;
		t_boot;
		t_map;
		t_refuse;
		t_level;
		t_edge;
		t_wake;
		t_idle;
		t_reset;
		end_of_test;
	end
	// Watchdog, far past the expected few thousand cycles
	initial begin
		#1000000;
		mismatches++;
		end_of_test;
	end
endmodule
